// ===== hdl/ifo_force_ctrl.sv
// Purpose : per-input force override with inactivity and fault shutdown
// Assumes : apb slave, one wait state per access; logic outputs on core_clk
// Notes   : pin inputs pass a three-stage synchroniser with agreement filter
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps

// Overview of operation
// - forced low input seen low by logic
// - forced high input seen high by logic
// - released input shows its physical level again
// - flag forced inputs differing from physical level
// - override touches only logic inputs, not pins
// - fast cutoff path uses raw physical inputs
// - gateway pass-through inputs ignore forcing
// - one override per input, project wide
// - over sixteen output changes may report later
// - contactor feedback monitoring stays on while forcing
// - process image carries physical inputs, real outputs
// - force mode ends on stop or timeout
// - detected fault ends force mode after 30s
// - on end outputs low, application stopped
// - inactivity timer expiry ends force mode
// - each force action reloads inactivity timer
// - keep-alive reloads timer, overrides unchanged
// - warning raised fifteen seconds before expiry
// - without reload, mode ends at expiry
// - reject logout, config transfer, stop while forcing
module ifo_force_ctrl
  import ifo_pkg::*;
#(
  parameter int unsigned N_IN      = 16,              // number of safety inputs
  parameter int unsigned N_OUT     = 16,              // number of outputs
  parameter int unsigned MS_CLOCKS = MS_CYCLES        // clocks per ms, shorten in sim
)(
  input  wire logic               core_clk,           // 25 MHz logic clock
  input  wire logic               reset,              // async reset, active high
  input  wire ifo_apb_req_s       apb_req,            // apb request from master
  output ifo_apb_rsp_s            apb_rsp,            // apb answer
  input  wire logic [N_IN-1:0]    phys_in,            // physical input pins
  input  wire logic [N_OUT-1:0]   prog_out,           // outputs computed by logic
  input  wire logic               fault_in,           // fault such as link loss
  output logic [N_IN-1:0]         logic_in,           // inputs fed to the logic
  output logic [N_IN-1:0]         mismatch,           // forced value differs from pin
  output logic [N_IN-1:0]         cutoff_in,          // raw inputs for fast cutoff
  output logic [N_IN-1:0]         gateway_in,         // raw inputs to network gateway
  output logic [N_IN-1:0]         image_in,           // process image inputs
  output logic [N_OUT-1:0]        image_out,          // process image outputs
  output logic [N_OUT-1:0]        hw_out,             // actual output drive
  output logic                    force_active,       // force mode running
  output logic                    force_warn,         // warning pending, sticky
  output logic                    app_run,            // application running
  output logic                    contactor_feedback_monitor_en, // feedback checks enabled
  output logic [2:0]              req_grant           // accepted logout/cfg/halt pulses
);

  // ***************************************************************
  // elaboration checks
  // ***************************************************************
  if (N_IN < 1 || N_IN > IFO_MAXW || N_OUT < 1 || N_OUT > IFO_MAXW || MS_CLOCKS < 1)
  begin : g_bad_params
    $error("ifo_force_ctrl: widths must be 1..32 and MS_CLOCKS at least 1");
  end

  localparam logic [31:0] MS_LAST = 32'(MS_CLOCKS - 1); // prescaler wrap value

  // ***************************************************************
  // helpers
  // ***************************************************************
  // value seen by logic for one input
  function automatic logic view_of(input ifo_ovr_e o, input logic p);
    logic v;
    v = p;
    if (o == OVR_LOW)
    begin
      v = 1'b0;
    end
    else if (o == OVR_HIGH)
    begin
      v = 1'b1;
    end
    return v;
  endfunction : view_of

  // delay in seconds to milliseconds
  function automatic logic [31:0] ms_of(input logic [15:0] s);
    return 32'({16'h0000, s} * MS_PER_S);
  endfunction : ms_of

  // number of set bits
  function automatic int unsigned ones(input logic [IFO_MAXW-1:0] v);
    int unsigned c;
    c = 0;
    for (int i = 0; i < IFO_MAXW; i++)
    begin
      c += int'(v[i]);
    end
    return c;
  endfunction : ones

  ifo_state_s st;                                     // registered state
  ifo_state_s n;                                      // next state
  logic       wr_go;                                  // write taken this edge
  logic       cmd_start;                              // decoded strobes
  logic       cmd_stop;
  logic       cmd_keep;
  logic       cmd_force;
  logic       end_expire;                             // termination causes
  logic       end_fault;
  logic       tick;                                   // millisecond tick
  logic [IFO_MAXW-1:0] diff;                          // unreported output changes
  logic [IFO_MAXW-1:0] in_mask;                       // valid input lanes
  logic [IFO_MAXW-1:0] out_mask;                      // valid output lanes

  assign in_mask  = IFO_MAXW'({N_IN{1'b1}});
  assign out_mask = IFO_MAXW'({N_OUT{1'b1}});

  // ***************************************************************
  // next-state logic
  // ***************************************************************
  always_comb
  begin
    n = st;
    // pins: three flops, a change counts when stages two and three agree
    n.sync1 = IFO_MAXW'(phys_in);
    n.sync2 = st.sync1;
    n.sync3 = st.sync2;
    n.phys  = (st.sync2 & st.sync3) | (st.phys & (st.sync2 ^ st.sync3));
    n.grant = 3'b000;
    n.mon_en = 1'b1;

    // apb: first access cycle raises pready, the next edge completes
    wr_go = apb_req.psel & apb_req.penable & apb_req.pwrite & st.rsp.pready;
    n.rsp.pready = apb_req.psel & apb_req.penable & ~st.rsp.pready;
    cmd_start = 1'b0;
    cmd_stop  = 1'b0;
    cmd_keep  = 1'b0;
    cmd_force = 1'b0;
    if (apb_req.psel & apb_req.penable & ~st.rsp.pready)
    begin
      // read data and error prepared one cycle ahead of completion
      n.rsp.pslverr = 1'b0;
      n.rsp.prdata  = 32'h0000_0000;
      if (apb_req.paddr == ADDR_CTRL)
      begin
        n.rsp.prdata = 32'h0000_0000;                 // strobes read as zero
      end
      else if (apb_req.paddr == ADDR_DELAY)
      begin
        n.rsp.prdata = {16'h0000, st.delay_s};
      end
      else if (apb_req.paddr == ADDR_FORCE)
      begin
        n.rsp.prdata = {22'h000000, st.force_reg};
      end
      else if (apb_req.paddr == ADDR_STATUS)
      begin
        n.rsp.prdata = {24'h000000, fault_in, st.app_run, st.sticky[5:1], st.mode == FM_ACTIVE};
      end
      else if (apb_req.paddr == ADDR_REMAIN)
      begin
        n.rsp.prdata = st.inact_ms;
      end
      else if (apb_req.paddr == ADDR_PHYS)
      begin
        n.rsp.prdata = st.phys & in_mask;
      end
      else if (apb_req.paddr == ADDR_VIEW)
      begin
        n.rsp.prdata = st.view & in_mask;
      end
      else if (apb_req.paddr == ADDR_MISMATCH)
      begin
        n.rsp.prdata = st.mism & in_mask;
      end
      else if (apb_req.paddr == ADDR_OUTIMG)
      begin
        n.rsp.prdata = st.out_img & out_mask;
      end
      else
      begin
        n.rsp.pslverr = 1'b1;                         // unmapped: error, data zero
      end
    end

    // write side effects
    if (wr_go && apb_req.paddr == ADDR_CTRL)
    begin
      cmd_start = apb_req.pwdata[CB_START];
      cmd_stop  = apb_req.pwdata[CB_STOP];
      cmd_keep  = apb_req.pwdata[CB_KEEP];
      if (st.mode == FM_ACTIVE && (apb_req.pwdata[CB_LOGOUT] | apb_req.pwdata[CB_CFG] | apb_req.pwdata[CB_HALT]))
      begin
        n.sticky[SB_REJECT] = 1'b1;
      end
      else if (st.mode == FM_IDLE)
      begin
        n.grant = {apb_req.pwdata[CB_HALT], apb_req.pwdata[CB_CFG], apb_req.pwdata[CB_LOGOUT]};
        if (apb_req.pwdata[CB_HALT])
        begin
          n.app_run = 1'b0;                           // controller stopped
        end
        else if (apb_req.pwdata[CB_RUN])
        begin
          n.app_run = 1'b1;                           // restart after a stop
          n.kill    = 1'b0;
        end
      end
    end
    else if (wr_go && apb_req.paddr == ADDR_DELAY)
    begin
      n.delay_s = apb_req.pwdata[15:0];               // used at the next entry
    end
    else if (wr_go && apb_req.paddr == ADDR_FORCE)
    begin
      cmd_force   = 1'b1;
      n.force_reg = apb_req.pwdata[9:0];
    end
    else if (wr_go && apb_req.paddr == ADDR_STATUS)
    begin
      // write one to clear; an event in the same cycle is set below and wins
      n.sticky = st.sticky & ~(apb_req.pwdata[7:0] & STICKY_MASK);
    end

    // millisecond timebase, held clear while idle
    tick = (st.mode == FM_ACTIVE) && (st.presc == MS_LAST);
    end_expire = tick && (st.inact_ms <= 32'h0000_0001);
    end_fault  = tick && fault_in && (st.fault_ms >= FAULT_MS - 32'h0000_0001);

    case (st.mode)
      FM_IDLE:
      begin
        if (cmd_start)
        begin
          n.mode     = FM_ACTIVE;
          n.load_ms  = ms_of(st.delay_s);             // delay chosen at entry
          n.inact_ms = ms_of(st.delay_s);
        end
      end
      FM_ACTIVE:
      begin
        n.presc = tick ? 32'h0000_0000 : st.presc + 32'h0000_0001;
        if (tick)
        begin
          n.inact_ms = st.inact_ms - 32'h0000_0001;
          n.fault_ms = fault_in ? st.fault_ms + 32'h0000_0001 : 32'h0000_0000;
          if (st.inact_ms == WARN_MS + 32'h0000_0001)
          begin
            n.sticky[SB_WARN] = 1'b1;
          end
        end
        if (cmd_force && !cmd_stop)
        begin
          // single override per input, shared by every page
          n.ovr[apb_req.pwdata[FR_IDX_LSB +: FR_IDX_W]] = ifo_ovr_e'(apb_req.pwdata[FR_ST_LSB +: 2]);
        end
        if (cmd_force || cmd_keep)
        begin
          n.inact_ms = st.load_ms;
        end
        if (cmd_stop || end_expire || end_fault)
        begin
          // any end: overrides cleared, outputs low, application stopped
          n.mode     = FM_IDLE;
          n.ovr      = '0;
          n.kill     = 1'b1;
          n.app_run  = 1'b0;
          n.inact_ms = 32'h0000_0000;
          n.fault_ms = 32'h0000_0000;
          n.presc    = 32'h0000_0000;
          n.sticky[SB_STOP]   = n.sticky[SB_STOP] | cmd_stop;
          n.sticky[SB_EXPIRE] = n.sticky[SB_EXPIRE] | (end_expire & ~cmd_stop);
          n.sticky[SB_FAULT]  = n.sticky[SB_FAULT] | (end_fault & ~cmd_stop & ~end_expire);
        end
      end
      default:
      begin
        n.mode = FM_IDLE;
      end
    endcase

    // logic view and mismatch from the registered override state
    for (int i = 0; i < IFO_MAXW; i++)
    begin
      n.view[i] = view_of(st.ovr[i], st.phys[i]);
      n.mism[i] = (st.ovr[i] != OVR_NONE) && (view_of(st.ovr[i], st.phys[i]) != st.phys[i]);
    end

    // actual outputs: logic result unless shutdown holds them low
    n.hw_out = st.kill ? '0 : (IFO_MAXW'(prog_out) & out_mask);

    // report lane by lane when too many outputs change at once
    diff = st.hw_out ^ st.out_img;
    if (ones(diff) > REPORT_MAX)
    begin
      n.out_img = st.lane ? ((st.out_img & ~LANE_HI) | (st.hw_out & LANE_HI))
                          : ((st.out_img & ~LANE_LO) | (st.hw_out & LANE_LO));
      n.lane    = ~st.lane;
    end
    else
    begin
      n.out_img = st.hw_out;
    end
  end

  // ***************************************************************
  // state register
  // ***************************************************************
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      st          <= '0;
      st.delay_s  <= DELAY_RST;
      st.kill     <= 1'b1;                            // outputs low until started
    end
    else
    begin
      st <= n;
    end
  end

  // ***************************************************************
  // outputs, all straight from flops
  // ***************************************************************
  assign apb_rsp       = st.rsp;
  assign logic_in      = st.view[N_IN-1:0];
  assign mismatch      = st.mism[N_IN-1:0];
  assign cutoff_in     = st.phys[N_IN-1:0];
  assign gateway_in    = st.phys[N_IN-1:0];
  assign image_in      = st.phys[N_IN-1:0];
  assign image_out     = st.out_img[N_OUT-1:0];
  assign hw_out        = st.hw_out[N_OUT-1:0];
  assign force_active  = (st.mode == FM_ACTIVE);
  assign force_warn    = st.sticky[SB_WARN];
  assign app_run       = st.app_run;
  assign contactor_feedback_monitor_en = st.mon_en;
  assign req_grant     = st.grant;

  // ***************************************************************
  // assertions
  // ***************************************************************
  a_force_low_view: assert property (@(posedge core_clk) disable iff (reset)
    (st.ovr[0] == OVR_LOW) |=> !logic_in[0])
    else $error("forced low input not seen low");

  a_force_high_view: assert property (@(posedge core_clk) disable iff (reset)
    (st.ovr[0] == OVR_HIGH) |=> logic_in[0])
    else $error("forced high input not seen high");

  a_release_phys: assert property (@(posedge core_clk) disable iff (reset)
    (st.ovr[0] == OVR_NONE) |=> (logic_in[0] == $past(st.phys[0])))
    else $error("released input not following pin");

  a_gateway_raw: assert property (@(posedge core_clk) disable iff (reset)
    (st.ovr != '0) |=> (gateway_in == $past(n.phys[N_IN-1:0])))
    else $error("gateway input altered by force");

  a_end_kills: assert property (@(posedge core_clk) disable iff (reset)
    (force_active ##1 !force_active) |=> (hw_out == '0 && !app_run))
    else $error("outputs not low after force end");

  a_idle_timers: assert property (@(posedge core_clk) disable iff (reset)
    !force_active |-> (st.inact_ms == 32'h0 && st.fault_ms == 32'h0 && st.presc == 32'h0))
    else $error("timers running while idle");

  a_reload_action: assert property (@(posedge core_clk) disable iff (reset)
    (force_active && n.mode == FM_ACTIVE && (cmd_force || cmd_keep)) |=> (st.inact_ms == $past(st.load_ms)))
    else $error("force action did not reload timer");

  a_reject_busy: assert property (@(posedge core_clk) disable iff (reset)
    (force_active && wr_go && apb_req.paddr == ADDR_CTRL && apb_req.pwdata[CB_HALT])
      |=> (st.sticky[SB_REJECT] && req_grant == 3'b000 && force_active))
    else $error("request accepted while forcing");

  a_ovr_cleared: assert property (@(posedge core_clk) disable iff (reset)
    !force_active |-> (st.ovr == '0))
    else $error("override left after force end");

endmodule : ifo_force_ctrl

// ===== hdl/ifo_pkg.sv
// Purpose : shared constants and carriers for the input force override block
// Assumes : 32-bit apb data, one aligned word per register
// Notes   : widths are sized for up to 32 inputs and 32 outputs
package ifo_pkg;

  // ***************************************************************
  // sizes and timing
  // ***************************************************************
  localparam int unsigned IFO_MAXW     = 32;           // widest input or output vector
  localparam int unsigned CLK_HZ       = 25_000_000;   // core_clk rate in hertz
  localparam int unsigned MS_PER_S     = 1000;         // milliseconds per second
  localparam int unsigned MS_CYCLES    = CLK_HZ / MS_PER_S; // clocks per millisecond
  localparam int unsigned WARN_S       = 15;           // warning lead time in seconds
  localparam int unsigned FAULT_S      = 30;           // fault shutdown time in seconds
  localparam logic [31:0] WARN_MS      = 32'(WARN_S * MS_PER_S);
  localparam logic [31:0] FAULT_MS     = 32'(FAULT_S * MS_PER_S);
  localparam int unsigned REPORT_MAX   = 16;           // output changes reported per cycle
  localparam logic [31:0] LANE_LO      = 32'h0000ffff; // low report lane
  localparam logic [31:0] LANE_HI      = 32'hffff0000; // high report lane

  // ***************************************************************
  // register map (byte addresses)
  // ***************************************************************
  localparam logic [7:0] ADDR_CTRL     = 8'h00;        // command strobes, write only
  localparam logic [7:0] ADDR_DELAY    = 8'h04;        // inactivity delay in seconds
  localparam logic [7:0] ADDR_FORCE    = 8'h08;        // force action: index and state
  localparam logic [7:0] ADDR_STATUS   = 8'h0c;        // mode and sticky events
  localparam logic [7:0] ADDR_REMAIN   = 8'h10;        // inactivity time left in ms
  localparam logic [7:0] ADDR_PHYS     = 8'h14;        // physical input levels
  localparam logic [7:0] ADDR_VIEW     = 8'h18;        // values the logic program sees
  localparam logic [7:0] ADDR_MISMATCH = 8'h1c;        // forced inputs differing from pin
  localparam logic [7:0] ADDR_OUTIMG   = 8'h20;        // reported output image

  // ctrl bits
  localparam int unsigned CB_START  = 0;               // enter force mode
  localparam int unsigned CB_STOP   = 1;               // leave force mode
  localparam int unsigned CB_KEEP   = 2;               // keep-alive
  localparam int unsigned CB_LOGOUT = 3;               // logout request
  localparam int unsigned CB_CFG    = 4;               // configuration upload/compare
  localparam int unsigned CB_HALT   = 5;               // controller stop request
  localparam int unsigned CB_RUN    = 6;               // start the application
  // force register fields
  localparam int unsigned FR_IDX_LSB = 0;
  localparam int unsigned FR_IDX_W   = 5;
  localparam int unsigned FR_ST_LSB  = 8;
  // status bits
  localparam int unsigned SB_ACTIVE = 0;
  localparam int unsigned SB_WARN   = 1;               // sticky, write one to clear
  localparam int unsigned SB_EXPIRE = 2;               // sticky
  localparam int unsigned SB_FAULT  = 3;               // sticky
  localparam int unsigned SB_STOP   = 4;               // sticky
  localparam int unsigned SB_REJECT = 5;               // sticky
  localparam int unsigned SB_RUN    = 6;
  localparam int unsigned SB_FLT_IN = 7;
  localparam logic [7:0]  STICKY_MASK = 8'h3e;         // bits that write one to clear
  localparam logic [15:0] DELAY_RST   = 16'h012c;      // default delay, seconds

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [1:0] {OVR_NONE, OVR_LOW, OVR_HIGH} ifo_ovr_e;
  typedef enum logic {FM_IDLE, FM_ACTIVE} ifo_mode_e;

  typedef struct packed {
    logic        psel;      // slave selected
    logic        penable;   // access phase
    logic        pwrite;    // write direction
    logic [7:0]  paddr;     // byte address
    logic [31:0] pwdata;    // write data
  } ifo_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;    // read data
    logic        pready;    // transfer done
    logic        pslverr;   // unmapped address
  } ifo_apb_rsp_s;

  typedef struct packed {
    ifo_mode_e                         mode;      // force mode state
    ifo_ovr_e [IFO_MAXW-1:0]           ovr;       // one override per input
    logic [IFO_MAXW-1:0]               sync1;     // pin synchroniser stages
    logic [IFO_MAXW-1:0]               sync2;
    logic [IFO_MAXW-1:0]               sync3;
    logic [IFO_MAXW-1:0]               phys;      // debounced physical levels
    logic [IFO_MAXW-1:0]               view;      // logic program inputs
    logic [IFO_MAXW-1:0]               mism;      // forced value differs
    logic [IFO_MAXW-1:0]               hw_out;    // actual outputs
    logic [IFO_MAXW-1:0]               out_img;   // reported output image
    logic                              lane;      // report lane when deferring
    logic [15:0]                       delay_s;   // configured delay
    logic [31:0]                       load_ms;   // delay latched at entry
    logic [31:0]                       inact_ms;  // inactivity time left
    logic [31:0]                       fault_ms;  // fault time accumulated
    logic [31:0]                       presc;     // millisecond prescaler
    logic [9:0]                        force_reg; // last force action
    logic [7:0]                        sticky;    // sticky status bits
    logic                              kill;      // outputs held low
    logic                              app_run;   // application running
    logic                              mon_en;    // feedback monitoring enabled
    logic [2:0]                        grant;     // accepted request pulses
    ifo_apb_rsp_s                      rsp;       // apb answer
  } ifo_state_s;

endpackage : ifo_pkg

// ===== test/ifo_tool_model.sv
// Purpose: configuration tool side, apb master with transfer task
// Assumes: one aligned 32-bit word per register
// Notes  : released bus shows inverted values, never the old ones
`timescale 1ns/1ps
module ifo_tool_model
  import ifo_pkg::*;
(
  input  wire logic   core_clk,  // logic clock
  output ifo_apb_req_s apb_req,  // request to block
  input  wire ifo_apb_rsp_s apb_rsp // answer
);
  initial apb_req = '0;
  // ****************************************
  // one apb transfer, waits for pready
  // ****************************************
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    do @(posedge core_clk); while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    // released: inverse so stale values are never reused
    apb_req <= '{1'b0, 1'b0, ~w, ~a, ~d};
  endtask : xfer
endmodule : ifo_tool_model

// ===== test/input_force_override_timeout_tb.sv
// Purpose: self-checking bench for the force override block
// Assumes: MS_CLOCKS of 1 so one ms is one clock
// Notes  : inputs held steady around each check
`timescale 1ns/1ps
`define CHK(a,b) begin cmp_count++; if ((a)!==(b)) begin fail_count++; $display("ERROR %0t %h vs %h",$time,a,b); end end
module input_force_override_timeout_tb;
  import ifo_pkg::*;
  logic core_clk = 0, reset = 1, fault_in = 0, fa, fw, ar, cm, gs = 0;
  logic [15:0] phys_in = 0, li, mm, ci, gi, ii;
  logic [31:0] prog_out = 0, io, ho;
  logic [2:0] rg;
  logic [31:0] q, rs = 32'hf8417e03, ex;
  int fail_count = 0, cmp_count = 0, cyc = 0, n;
  ifo_apb_req_s rq;
  ifo_apb_rsp_s rp;
  always #20 core_clk = ~core_clk;
  ifo_force_ctrl #(.MS_CLOCKS(1), .N_OUT(32)) ifo_force_ctrl_i (.core_clk, .reset, .apb_req(rq), .apb_rsp(rp), .phys_in,
    .prog_out, .fault_in, .logic_in(li), .mismatch(mm), .cutoff_in(ci), .gateway_in(gi), .image_in(ii),
    .image_out(io), .hw_out(ho), .force_active(fa), .force_warn(fw), .app_run(ar),
    .contactor_feedback_monitor_en(cm), .req_grant(rg));
  ifo_tool_model ifo_tool_model_i (.core_clk, .apb_req(rq), .apb_rsp(rp));
  // any accepted request pulse is remembered
  always @(posedge core_clk) if (rg != 3'h0) gs <= 1'b1;
  // hang guard
  always @(posedge core_clk) if (++cyc == 90000) begin fail_count++; print_verdict(); end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13; s ^= s >> 17; return s ^ (s << 5);
  endfunction : xs
  task automatic wr(input logic [7:0] a, input logic [31:0] d); ifo_tool_model_i.xfer(1'b1, a, d, q); endtask : wr
  task automatic rd(input logic [7:0] a); ifo_tool_model_i.xfer(1'b0, a, 32'h0, q); endtask : rd
  task automatic idle_wait(output int c);
    c = 0;
    while (fa === 1'b1 && c < 40000) begin @(posedge core_clk); c++; end
  endtask : idle_wait
  task automatic print_verdict();
    $display("checks %0d errors %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    rs = xs(rs); phys_in <= rs[15:0]; prog_out <= rs;
    rd(ADDR_DELAY); `CHK(q[15:0], DELAY_RST)
    rd(8'h40); `CHK(rp.pslverr, 1'b1)
    `CHK(cm, 1'b1)
    wr(ADDR_CTRL, 32'h48); repeat (2) @(posedge core_clk); `CHK(gs, 1'b1)
    repeat (3) @(posedge core_clk); gs <= 1'b0;
    `CHK(ho, prog_out)
    // more than sixteen outputs switching: image catches up one lane per cycle
    prog_out <= 32'h0; repeat (4) @(posedge core_clk);
    prog_out <= 32'hffffffff; repeat (3) @(posedge core_clk);
    `CHK(ho, 32'hffffffff)
    `CHK(io == 32'h0000ffff || io == 32'hffff0000, 1'b1)
    @(posedge core_clk); `CHK(io, ho)
    wr(ADDR_DELAY, 32'd16); wr(ADDR_CTRL, 32'h1);
    @(posedge core_clk); `CHK(fa, 1'b1)
    for (int k = 0; k < 6; k++) begin
      rs = xs(rs); n = (k < 2) ? 0 : rs[3:0]; ex = phys_in;
      for (int s = 1; s >= 0; s--) begin
        wr(ADDR_FORCE, {22'h0, ((k % 2) ? 2'h2 : 2'h1) & {2{s[0]}}, 3'h0, 5'(n)});
        repeat (3) @(posedge core_clk);
        if (s == 1) ex[n] = k % 2; else ex[n] = phys_in[n];
        `CHK(li, ex[15:0])
        `CHK(mm, (ex[15:0] ^ phys_in))
        `CHK({ci, gi, ii}, {3{phys_in}})
      end
    end
    wr(ADDR_FORCE, 32'h105); wr(ADDR_CTRL, 32'h38);
    repeat (3) @(posedge core_clk);
    `CHK(gs, 1'b0)
    rd(ADDR_STATUS); `CHK(q[SB_REJECT], 1'b1)
    repeat (1100) @(posedge core_clk);
    `CHK(fw, 1'b1)
    wr(ADDR_CTRL, 32'h4); rd(ADDR_REMAIN);
    `CHK(q > 32'd15990 && q <= 32'd16000, 1'b1)
    `CHK(li[5], 1'b0)
    idle_wait(n);
    `CHK(n > 15980 && n <= 16000, 1'b1)
    @(posedge core_clk);
    `CHK({ho, ar, li}, {32'h0, 1'b0, phys_in})
    rd(ADDR_STATUS); `CHK(q[SB_EXPIRE], 1'b1)
    wr(ADDR_CTRL, 32'h1); wr(ADDR_CTRL, 32'h2);
    @(posedge core_clk); `CHK(fa, 1'b0)
    rd(ADDR_STATUS); `CHK(q[SB_STOP], 1'b1)
    wr(ADDR_DELAY, 32'd40); wr(ADDR_CTRL, 32'h1); fault_in <= 1'b1;
    @(posedge core_clk);
    idle_wait(n);
    `CHK(n > 29980 && n <= 30010, 1'b1)
    rd(ADDR_STATUS); `CHK(q[SB_FAULT], 1'b1)
    print_verdict();
  end
endmodule : input_force_override_timeout_tb
